// ---- core/lcd_mux_pkg.sv ----
// Shared constants, types and decoders for the segment LCD multiplexer
package lcd_mux_pkg;

  localparam int SEG_COUNT = 160;
  localparam int ROW_COUNT = 4;
  localparam int COL_AW    = 8;

  typedef logic [1:0] level_t;

  // Drive levels: Vss, lower mid (1/3, or 1/2 in half bias), upper mid (2/3), Vlcd
  localparam level_t LVL_VSS  = 2'h0;
  localparam level_t LVL_LOW  = 2'h1;
  localparam level_t LVL_HIGH = 2'h2;
  localparam level_t LVL_VLCD = 2'h3;
  localparam level_t IDLE_LEVEL = LVL_VLCD;

  typedef enum logic [3:0] {
    DRV_STATIC = 4'h1,
    DRV_MUX2   = 4'h2,
    DRV_MUX3   = 4'h4,
    DRV_MUX4   = 4'h8
  } drive_mode_t;

  // Mode selection codes on the mode_sel input
  localparam logic [1:0] SEL_MUX4   = 2'h0;
  localparam logic [1:0] SEL_STATIC = 2'h1;
  localparam logic [1:0] SEL_MUX2   = 2'h2;
  localparam logic [1:0] SEL_MUX3   = 2'h3;

  localparam drive_mode_t RST_MODE      = DRV_MUX4;
  localparam logic        RST_BIAS_HALF = 1'b0;
  localparam logic        RST_ENABLE    = 1'b0;
  localparam logic [3:0]  RST_RAM_WORD  = 4'h0;

  function automatic drive_mode_t decode_mode(input logic [1:0] sel);
    case (sel)
      SEL_STATIC: decode_mode = DRV_STATIC;
      SEL_MUX2:   decode_mode = DRV_MUX2;
      SEL_MUX3:   decode_mode = DRV_MUX3;
      default:    decode_mode = DRV_MUX4;
    endcase
  endfunction

  function automatic logic [1:0] last_row(input drive_mode_t m);
    case (m)
      DRV_STATIC: last_row = 2'h0;
      DRV_MUX2:   last_row = 2'h1;
      DRV_MUX3:   last_row = 2'h2;
      default:    last_row = 2'h3;
    endcase
  endfunction

endpackage

// ---- core/lcd_display_ram.sv ----
// Static 160 x 4 display memory with a column write port
`timescale 1ns/1ps
`default_nettype none
module lcd_display_ram
  import lcd_mux_pkg::*;
(
  input  wire logic                            mclk,
  input  wire logic                            rst_n,
  input  wire logic                            wr_en,
  input  wire logic [COL_AW-1:0]               wr_col,
  input  wire logic [ROW_COUNT-1:0]            wr_data,
  output logic      [SEG_COUNT-1:0][ROW_COUNT-1:0] ram_image
);
  logic [SEG_COUNT-1:0][ROW_COUNT-1:0] mem_r;
  logic [SEG_COUNT-1:0][ROW_COUNT-1:0] mem_nxt;

  // Column addresses past the last column are dropped
  always_comb begin
    mem_nxt = mem_r;
    if (wr_en && (wr_col < COL_AW'(SEG_COUNT))) begin
      mem_nxt[wr_col] = wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mem_r <= {SEG_COUNT{RST_RAM_WORD}};
    end else begin
      mem_r <= mem_nxt;
    end
  end

  assign ram_image = mem_r;

  a_ram_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_en && wr_col < COL_AW'(SEG_COUNT)) |=> mem_r[$past(wr_col)] == $past(wr_data))
    else $error("display memory write lost"); // R14
endmodule
`default_nettype wire

// ---- core/lcd_backplane_segment_mux.sv ----
// Backplane and segment drive level generator for a multiplexed segment LCD
//
// Functional notes
// R01: Drive outputs from latched display register copy
// R02: Levels follow drive mode and bias option
// R03: Exactly four backplane outputs, mode dependent
// R04: Static mode: all backplanes identical
// R05: Two-row mode, half or third bias
// R06: Two-row: pairs 0/2 and 1/3 identical
// R07: Three-row mode sequences three phases
// R08: Three-row: backplane 3 copies backplane 1
// R09: Four-row mode: four distinct phases
// R10: Half bias optional in three/four-row modes
// R11: Duplicate backplane pin groups, same waveform
// R12: 160 segment outputs numbered from zero
// R13: Segment combines phase with held data
// R14: Display memory 160 columns by 4 bits
// R15: Memory column maps to same segment
// R16: Memory row maps to same backplane
// R17: One means element on, zero off
// R18: Row n data shown in slot n
// R19: Reset selects four-row, third bias
// R20: Reset clears display enable
// R21: Disabled: idle outputs, sequencing suspended
`timescale 1ns/1ps
`default_nettype none
module lcd_backplane_segment_mux
  import lcd_mux_pkg::*;
(
  input  wire logic                                 mclk,
  input  wire logic                                 rst_n,
  input  wire logic                                 slot_tick,
  input  wire logic                                 mode_load,
  input  wire logic [1:0]                           mode_sel,
  input  wire logic                                 bias_half,
  input  wire logic                                 display_en,
  input  wire logic                                 wr_en,
  input  wire logic [lcd_mux_pkg::COL_AW-1:0]       wr_col,
  input  wire logic [lcd_mux_pkg::ROW_COUNT-1:0]    wr_data,
  output lcd_mux_pkg::level_t                       backplane_out_0,
  output lcd_mux_pkg::level_t                       backplane_out_1,
  output lcd_mux_pkg::level_t                       backplane_out_2,
  output lcd_mux_pkg::level_t                       backplane_out_3,
  output lcd_mux_pkg::level_t                       backplane_dup_0,
  output lcd_mux_pkg::level_t                       backplane_dup_1,
  output lcd_mux_pkg::level_t                       backplane_dup_2,
  output lcd_mux_pkg::level_t                       backplane_dup_3,
  output logic [lcd_mux_pkg::SEG_COUNT-1:0][1:0]    segment_outputs,
  output logic [1:0]                                active_row,
  output lcd_mux_pkg::drive_mode_t                  drive_mode
);
  import lcd_mux_pkg::*;

  // Backplane level: active row gets full swing, others sit on a mid level
  function automatic level_t bp_level(input logic act, input logic hf, input logic half_b);
    if (act) begin
      bp_level = hf ? LVL_VSS : LVL_VLCD;
    end else if (half_b) begin
      bp_level = LVL_LOW;
    end else begin
      bp_level = hf ? LVL_HIGH : LVL_LOW;
    end
  endfunction

  // Segment level: on is antiphase to the active backplane, off is in phase
  function automatic level_t seg_level(input logic on, input logic hf, input logic two_lvl);
    if (on) begin
      seg_level = hf ? LVL_VLCD : LVL_VSS;
    end else if (two_lvl) begin
      seg_level = hf ? LVL_VSS : LVL_VLCD;
    end else begin
      seg_level = hf ? LVL_LOW : LVL_HIGH;
    end
  endfunction

  logic [SEG_COUNT-1:0][ROW_COUNT-1:0] ram_image;

  // R14 display memory
  lcd_display_ram u_ram (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .wr_en     (wr_en),
    .wr_col    (wr_col),
    .wr_data   (wr_data),
    .ram_image (ram_image)
  );

  // Configuration group
  drive_mode_t mode_r;
  drive_mode_t mode_nxt;
  logic        half_bias_r;
  logic        half_bias_nxt;
  logic        en_r;
  logic        en_nxt;

  // R02 mode command latch
  always_comb begin
    mode_nxt      = mode_r;
    half_bias_nxt = half_bias_r;
    en_nxt        = en_r;
    if (mode_load) begin
      mode_nxt      = decode_mode(mode_sel);
      half_bias_nxt = bias_half;
      en_nxt        = display_en;
    end
  end

  // R19 R20 reset configuration
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_r      <= RST_MODE;
      half_bias_r <= RST_BIAS_HALF;
      en_r        <= RST_ENABLE;
    end else begin
      mode_r      <= mode_nxt;
      half_bias_r <= half_bias_nxt;
      en_r        <= en_nxt;
    end
  end

  // Sequencer group: row slot and the inverted half of each slot
  logic [1:0] row_r;
  logic [1:0] row_nxt;
  logic       hf_r;
  logic       hf_nxt;
  logic       frame_wrap;
  logic       load_frame;
  logic [SEG_COUNT-1:0][ROW_COUNT-1:0] hold_r;
  logic [SEG_COUNT-1:0][ROW_COUNT-1:0] hold_nxt;

  assign frame_wrap = en_r && slot_tick && hf_r && (row_r >= last_row(mode_r));
  assign load_frame = !en_r || frame_wrap;

  // R07 R09 R21 slot sequencing
  always_comb begin
    row_nxt = row_r;
    hf_nxt  = hf_r;
    if (!en_r || mode_load) begin
      row_nxt = 2'h0;
      hf_nxt  = 1'b0;
    end else if (slot_tick) begin
      hf_nxt = !hf_r;
      if (hf_r) begin
        row_nxt = (row_r >= last_row(mode_r)) ? 2'h0 : row_r + 2'h1;
      end
    end
  end

  // R01 display register
  always_comb begin
    hold_nxt = load_frame ? ram_image : hold_r;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      row_r  <= 2'h0;
      hf_r   <= 1'b0;
      hold_r <= {SEG_COUNT{RST_RAM_WORD}};
    end else begin
      row_r  <= row_nxt;
      hf_r   <= hf_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Output group; registered, so pins trail the sequencer by one cycle
  level_t [ROW_COUNT-1:0] bp_r;
  level_t [ROW_COUNT-1:0] bp_nxt;
  level_t [ROW_COUNT-1:0] dup_r;
  logic   [SEG_COUNT-1:0][1:0] seg_r;
  logic   [SEG_COUNT-1:0][1:0] seg_nxt;
  logic   [ROW_COUNT-1:0] bp_act;
  logic                   two_lvl;

  // R03 R04 R06 R08 R09 R16 active backplane per mode
  always_comb begin
    bp_act = 4'h0;
    case (mode_r)
      DRV_STATIC: bp_act = 4'hf;
      DRV_MUX2:   bp_act = (row_r == 2'h0) ? 4'h5 : 4'ha;
      DRV_MUX3: begin
        case (row_r)
          2'h0:    bp_act = 4'h1;
          2'h1:    bp_act = 4'ha;
          default: bp_act = 4'h4;
        endcase
      end
      default: bp_act = 4'h1 << row_r;
    endcase
  end

  // Static and half bias segments only swing between the rails
  assign two_lvl = (mode_r == DRV_STATIC) || half_bias_r;

  // R02 R05 R10 R13 R15 R17 R18 R21 level selection
  always_comb begin
    bp_nxt  = {ROW_COUNT{IDLE_LEVEL}};
    seg_nxt = {SEG_COUNT{IDLE_LEVEL}};
    if (en_r) begin
      for (int b = 0; b < ROW_COUNT; b++) begin
        bp_nxt[b] = bp_level(bp_act[b], hf_r, half_bias_r && mode_r != DRV_STATIC);
      end
      for (int s = 0; s < SEG_COUNT; s++) begin
        seg_nxt[s] = seg_level(hold_r[s][row_r], hf_r, two_lvl);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bp_r  <= {ROW_COUNT{IDLE_LEVEL}};
      dup_r <= {ROW_COUNT{IDLE_LEVEL}};
      seg_r <= {SEG_COUNT{IDLE_LEVEL}};
    end else begin
      bp_r  <= bp_nxt;
      dup_r <= bp_nxt;
      seg_r <= seg_nxt;
    end
  end

  // R11 R12 pin groups
  assign backplane_out_0 = bp_r[0];
  assign backplane_out_1 = bp_r[1];
  assign backplane_out_2 = bp_r[2];
  assign backplane_out_3 = bp_r[3];
  assign backplane_dup_0 = dup_r[0];
  assign backplane_dup_1 = dup_r[1];
  assign backplane_dup_2 = dup_r[2];
  assign backplane_dup_3 = dup_r[3];
  assign segment_outputs = seg_r;
  assign active_row      = row_r;
  assign drive_mode      = mode_r;

  // Count of backplanes at a rail level, used by the four-row check
  logic [2:0] rail_cnt;
  always_comb begin
    rail_cnt = 3'h0;
    for (int b = 0; b < ROW_COUNT; b++) begin
      if (bp_r[b] == LVL_VSS || bp_r[b] == LVL_VLCD) begin
        rail_cnt = rail_cnt + 3'h1;
      end
    end
  end

  a_reset_config: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(rst_n) |-> (mode_r == DRV_MUX4 && !half_bias_r && !en_r)) // R19
    else $error("reset configuration wrong");

  a_idle_outputs: assert property (@(posedge mclk) disable iff (!rst_n)
    (!en_r) |=> (bp_r == {ROW_COUNT{IDLE_LEVEL}} && seg_r[0] == IDLE_LEVEL
                 && seg_r[SEG_COUNT-1] == IDLE_LEVEL)) // R21
    else $error("outputs not idle while disabled");

  a_seq_suspend: assert property (@(posedge mclk) disable iff (!rst_n)
    (!en_r && !mode_load) [*2] |-> (row_r == 2'h0 && !hf_r)) // R21
    else $error("sequencer runs while disabled");

  a_static_same: assert property (@(posedge mclk) disable iff (!rst_n)
    (en_r && mode_r == DRV_STATIC) |=> (bp_r[0] == bp_r[1] && bp_r[1] == bp_r[2]
                                         && bp_r[2] == bp_r[3])) // R04
    else $error("static backplanes differ");

  a_mux2_pairs: assert property (@(posedge mclk) disable iff (!rst_n)
    (en_r && mode_r == DRV_MUX2) |=> (bp_r[0] == bp_r[2] && bp_r[1] == bp_r[3]
                                       && bp_r[0] != bp_r[1])) // R06
    else $error("two-row backplane pairing wrong");

  a_mux3_copy: assert property (@(posedge mclk) disable iff (!rst_n)
    (en_r && mode_r == DRV_MUX3) |=> (bp_r[3] == bp_r[1])) // R08
    else $error("three-row backplane copy wrong");

  a_mux4_one: assert property (@(posedge mclk) disable iff (!rst_n)
    (en_r && mode_r == DRV_MUX4 && !half_bias_r) |=> (rail_cnt == 3'h1)) // R09
    else $error("four-row needs one active backplane");

  a_dup_match: assert property (@(posedge mclk) disable iff (!rst_n)
    (bp_r == dup_r)) // R11
    else $error("duplicate backplane pins differ");

  a_row_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    (row_r <= last_row(mode_r)) or $past(mode_load)) // R07
    else $error("row slot beyond mode");

  a_hold_stable: assert property (@(posedge mclk) disable iff (!rst_n)
    (!load_frame) |=> $stable(hold_r)) // R01
    else $error("display register changed mid frame");

  a_seg_data: assert property (@(posedge mclk) disable iff (!rst_n)
    (en_r && !hf_r) |=> (segment_outputs[0] ==
      ($past(hold_r[0][row_r]) ? LVL_VSS : ($past(two_lvl) ? LVL_VLCD : LVL_HIGH)))) // R17
    else $error("segment level does not match held data");

  c_static_frame: cover property (@(posedge mclk) disable iff (!rst_n)
    frame_wrap && mode_r == DRV_STATIC);
  c_mux2_frame: cover property (@(posedge mclk) disable iff (!rst_n)
    frame_wrap && mode_r == DRV_MUX2);
  c_mux3_frame: cover property (@(posedge mclk) disable iff (!rst_n)
    frame_wrap && mode_r == DRV_MUX3);
  c_mux4_half: cover property (@(posedge mclk) disable iff (!rst_n)
    frame_wrap && mode_r == DRV_MUX4 && half_bias_r);
endmodule
`default_nettype wire

// ---- bench/lcd_panel_model.sv ----
// Passive panel model: flags the elements of one segment column that see full drive
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model #(
  parameter int SEG_IDX = 0
) (
  input  wire logic [3:0][1:0]                         bp,
  input  wire logic [lcd_mux_pkg::SEG_COUNT-1:0][1:0] segs,
  output logic      [3:0]                              lit
);
  import lcd_mux_pkg::*;
  level_t seg;
  assign seg = segs[SEG_IDX];
  // Full swing lights
  // A mid level against either rail never reaches threshold, so only 0 against 3 counts
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      lit[b] = (bp[b] == LVL_VSS && seg == LVL_VLCD) || (bp[b] == LVL_VLCD && seg == LVL_VSS);
    end
  end
endmodule
`default_nettype wire

// ---- bench/lcd_backplane_segment_mux_tb.sv ----
// Self-checking bench for the backplane and segment multiplexer
`timescale 1ns/1ps
`default_nettype none
module lcd_backplane_segment_mux_tb;
  import lcd_mux_pkg::*;
  typedef struct packed {
    logic [1:0]  sel;
    logic        bias;
    drive_mode_t mode;
    logic [1:0]  last;
  } case_t;
  case_t                     rows [7];
  logic                      mclk, rst_n, slot_tick, mode_load, bias_half, display_en, wr_en;
  logic [1:0]                mode_sel, act_row;
  logic [COL_AW-1:0]         wr_col;
  logic [ROW_COUNT-1:0]      wr_data, lit;
  logic [3:0][1:0]           bp, dup;
  logic [SEG_COUNT-1:0][1:0] segs;
  drive_mode_t               mode_q;
  logic [3:0]                mem [SEG_COUNT];
  int                        n_errors, samples_checked;

  lcd_backplane_segment_mux dut (.mclk(mclk), .rst_n(rst_n), .slot_tick(slot_tick),
    .mode_load(mode_load), .mode_sel(mode_sel), .bias_half(bias_half),
    .display_en(display_en), .wr_en(wr_en), .wr_col(wr_col), .wr_data(wr_data),
    .backplane_out_0(bp[0]), .backplane_out_1(bp[1]), .backplane_out_2(bp[2]),
    .backplane_out_3(bp[3]), .backplane_dup_0(dup[0]), .backplane_dup_1(dup[1]),
    .backplane_dup_2(dup[2]), .backplane_dup_3(dup[3]), .segment_outputs(segs),
    .active_row(act_row), .drive_mode(mode_q));
  lcd_panel_model #(.SEG_IDX(159)) panel (.bp(bp), .segs(segs), .lit(lit));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge mclk);
    slot_tick <= 1'b1;
    @(posedge mclk);
    slot_tick <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic load(input logic [1:0] sel, input logic bias, input logic en);
    @(posedge mclk);
    mode_load <= 1'b1;
    mode_sel <= sel;
    bias_half <= bias;
    display_en <= en;
    @(posedge mclk);
    mode_load <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic write(input logic [7:0] col, input logic [3:0] data);
    @(posedge mclk);
    wr_en <= 1'b1;
    wr_col <= col;
    wr_data <= data;
    @(posedge mclk);
    wr_en <= 1'b0;
    if (col < SEG_COUNT) mem[col] = data;
    #1;
  endtask

  function automatic logic is_act(input drive_mode_t m, input logic [1:0] r, input int b);
    case (m)
      DRV_STATIC: return 1'b1;
      DRV_MUX2:   return b[0] == r[0];
      DRV_MUX3:   return (b == r) || (r == 2'h1 && b == 3);
      default:    return b == r;
    endcase
  endfunction

  task automatic check_idle();
    chk("active_row", 4'h0, act_row);
    for (int b = 0; b < 4; b++) begin
      chk("backplane", IDLE_LEVEL, bp[b]);
      chk("backplane_dup", IDLE_LEVEL, dup[b]);
    end
    for (int c = 0; c < SEG_COUNT; c++) chk("segment", IDLE_LEVEL, segs[c]);
  endtask

  task automatic check_slot(input drive_mode_t m, input logic bias, input logic [1:0] r,
                            input logic h);
    logic      a;
    logic      on;
    logic [1:0] e;
    chk("active_row", r, act_row);
    for (int b = 0; b < 4; b++) begin
      a = is_act(m, r, b);
      e = a ? (h ? 2'h0 : 2'h3) : (bias ? 2'h1 : (h ? 2'h2 : 2'h1));
      chk("backplane", e, bp[b]);
      chk("backplane_dup", e, dup[b]);
      chk("panel_element", a & mem[159][r], lit[b]);
    end
    for (int c = 0; c < SEG_COUNT; c++) begin
      on = mem[c][r];
      e = on ? (h ? 2'h3 : 2'h0) : ((m == DRV_STATIC || bias) ? (h ? 2'h0 : 2'h3)
                                                                : (h ? 2'h1 : 2'h2));
      chk("segment", e, segs[c]);
    end
  endtask

  task automatic run_frame(input case_t t);
    load(t.sel, t.bias, 1'b1);
    chk("drive_mode", t.mode, mode_q);
    for (int r = 0; r <= t.last; r++) begin
      for (int h = 0; h < 2; h++) begin
        check_slot(t.mode, t.bias, 2'(r), h[0]);
        tick();
      end
    end
    chk("active_row_wrap", 4'h0, act_row);
  endtask

  initial begin
    {slot_tick, mode_load, bias_half, display_en, wr_en} = 5'h00;
    mode_sel = 2'h0;
    wr_col = 8'h00;
    wr_data = 4'h0;
    rst_n = 1'b0;
    n_errors = 0;
    samples_checked = 0;
    for (int c = 0; c < SEG_COUNT; c++) mem[c] = 4'h0;
    rows = '{'{2'h0, 1'b0, DRV_MUX4, 2'h3}, '{2'h1, 1'b0, DRV_STATIC, 2'h0},
             '{2'h2, 1'b0, DRV_MUX2, 2'h1}, '{2'h2, 1'b1, DRV_MUX2, 2'h1},
             '{2'h3, 1'b0, DRV_MUX3, 2'h2}, '{2'h3, 1'b1, DRV_MUX3, 2'h2},
             '{2'h0, 1'b1, DRV_MUX4, 2'h3}};
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("drive_mode", DRV_MUX4, mode_q);
    check_idle();
    // Fill while disabled, the display register then tracks memory
    for (int c = 0; c < SEG_COUNT; c++) write(8'(c), 4'(c) ^ 4'(c >> 4));
    write(8'ha0, 4'hf);
    foreach (rows[i]) run_frame(rows[i]);
    // A write mid-frame stays hidden until the frame wraps
    load(2'h0, 1'b0, 1'b1);
    write(8'h00, 4'hf);
    mem[0] = 4'h0;
    check_slot(DRV_MUX4, 1'b0, 2'h0, 1'b0);
    repeat (8) tick();
    mem[0] = 4'hf;
    check_slot(DRV_MUX4, 1'b0, 2'h0, 1'b0);
    load(2'h0, 1'b0, 1'b0);
    tick();
    check_idle();
    load(2'h2, 1'b1, 1'b1);
    tick();
    @(posedge mclk);
    rst_n <= 1'b0;
    @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk("drive_mode", DRV_MUX4, mode_q);
    check_idle();
    for (int c = 0; c < SEG_COUNT; c++) mem[c] = 4'h0;
    run_frame(rows[0]);
    finish_test();
  end

  initial begin
    #200000;
    n_errors++;
    $display("mismatch watchdog expected done seen timeout");
    finish_test();
  end
endmodule
`default_nettype wire
